// file: inc/spt_pkg.sv
// Package with constants and helpers of the stepper phase translator.
package spt_pkg;

   // Register map, byte addresses on the APB.
   localparam logic [11:0] SPT_ADDR_CTRL = 12'h000;
   localparam logic [11:0] SPT_ADDR_STATUS = 12'h004;

   // Control register: chopper oscillator period in pclk cycles.
   localparam int SPT_CTRL_PERIOD_LSB = 0;
   localparam int SPT_CTRL_PERIOD_W = 16;
   localparam logic [15:0] SPT_PERIOD_RST = 16'h00c8;
   localparam logic [15:0] SPT_PERIOD_MIN = 16'h0002;

   // Status register field positions.
   localparam int SPT_ST_IDX_LSB = 0;
   localparam int SPT_ST_HOME = 3;
   localparam int SPT_ST_FF_AB = 4;
   localparam int SPT_ST_FF_CD = 5;
   localparam int SPT_ST_HALF = 6;
   localparam int SPT_ST_LOCAL = 7;
   localparam int SPT_ST_PHASE_LSB = 8;

   // Positions of the synchronised pins in the pin vector.
   localparam int SPT_PIN_STEP = 0;
   localparam int SPT_PIN_DIR = 1;
   localparam int SPT_PIN_HALF = 2;
   localparam int SPT_PIN_TRST = 3;
   localparam int SPT_PIN_EN = 4;
   localparam int SPT_PIN_CTRL = 5;
   localparam int SPT_PIN_SAB = 6;
   localparam int SPT_PIN_SCD = 7;
   localparam int SPT_PIN_OSC = 8;
   localparam int SPT_PIN_SYNC = 9;
   localparam int SPT_PIN_W = 10;
   // Pins reset to their idle levels, so no sense trip or sync edge follows.
   localparam logic [9:0] SPT_PIN_RST = 10'h11f;

   // Translator home position (state 1) and its phase pattern ABCD.
   localparam logic [2:0] SPT_HOME_IDX = 3'h0;
   localparam logic [3:0] SPT_HOME_PHASE = 4'h5;
   localparam logic [2:0] SPT_STEP_HALF = 3'h1;
   localparam logic [2:0] SPT_STEP_FULL = 3'h2;

   // Phase pattern ABCD (A in bit 3) for states 1 to 8, index 0 to 7.
   function automatic logic [3:0] spt_phase_of(input logic [2:0] idx);
      logic [3:0] p;
      p = SPT_HOME_PHASE;
      case (idx)
         3'h0: p = SPT_HOME_PHASE;
         3'h1: p = 4'h4;
         3'h2: p = 4'h6;
         3'h3: p = 4'h2;
         3'h4: p = 4'ha;
         3'h5: p = 4'h8;
         3'h6: p = 4'h9;
         3'h7: p = 4'h1;
         default: p = SPT_HOME_PHASE;
      endcase
      return p;
   endfunction

   // Chopping a pair on the phase lines turns on its idle line as well.
   function automatic logic [1:0] spt_chop_pair(input logic [1:0] pair);
      return (pair != 2'h0) ? 2'h3 : pair;
   endfunction

endpackage

// file: inc/spt_chop_if.sv
// Interface between the translator core and the dual chopper.
`timescale 1ns/1ns
interface spt_chop_if;
   logic local_en;
   logic [15:0] period;
   logic sync_level;
   logic sense_ab;
   logic sense_cd;
   logic pulse;
   logic ff_ab;
   logic ff_cd;

   modport core (
      output local_en,
      output period,
      output sync_level,
      output sense_ab,
      output sense_cd,
      input pulse,
      input ff_ab,
      input ff_cd
   );

   modport chop (
      input local_en,
      input period,
      input sync_level,
      input sense_ab,
      input sense_cd,
      output pulse,
      output ff_ab,
      output ff_cd
   );
endinterface

// file: rtl/spt_chopper.sv
// Dual chopper: shared oscillator and one drive flip-flop per winding pair.
`timescale 1ns/1ns
module spt_chopper (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Link to the translator core.
   spt_chop_if.chop ch
);
   import spt_pkg::*;

   typedef struct packed {
      logic [15:0] cnt;
      logic sync_d;
      logic pulse;
      logic ff_ab;
      logic ff_cd;
   } spt_chop_type;

   spt_chop_type r;
   spt_chop_type next_r;
   logic [15:0] lim;
   logic tick;

   always_comb begin
      next_r = r;
      lim = (ch.period < SPT_PERIOD_MIN) ? SPT_PERIOD_MIN : ch.period;
      tick = 1'b0;
      next_r.sync_d = ch.sync_level;
      if (ch.local_en) begin
         // Local oscillator free-runs and times the chopper itself.
         if (r.cnt >= lim - 16'h0001) begin
            next_r.cnt = 16'h0000;
            tick = 1'b1;
         end else begin
            next_r.cnt = r.cnt + 16'h0001;
         end
      end else begin
         // Oscillator grounded: follow pulses arriving on the sync pin.
         next_r.cnt = 16'h0000;
         tick = ch.sync_level && !r.sync_d;
      end
      next_r.pulse = tick;
      // Each pair is set by the pulse and cleared by its own comparator.
      if (tick) begin
         next_r.ff_ab = 1'b1;
      end else if (ch.sense_ab) begin
         next_r.ff_ab = 1'b0;
      end
      if (tick) begin
         next_r.ff_cd = 1'b1;
      end else if (ch.sense_cd) begin
         next_r.ff_cd = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '{cnt: 16'h0000, sync_d: 1'b0, pulse: 1'b0,
                ff_ab: 1'b1, ff_cd: 1'b1};
      end else begin
         r <= next_r;
      end
   end

   assign ch.pulse = r.pulse;
   assign ch.ff_ab = r.ff_ab;
   assign ch.ff_cd = r.ff_cd;

endmodule

// file: rtl/spt_translator.sv
// Stepper phase translator top: translator, output gating and APB registers.
//
// Overview of operation
// - Each rising edge of the low-pulsed step input, with translator reset high, moves the translator one state in half-step or two in full-step.
// - The direction input is synchronised like the step input, so it may change at any time and acts on the next rising step edge.
// - The home output releases its pull-down while the translator is in state 1, whose phases are 0101, even when disabled or chopped.
// - Enable low forces all four phases and both inhibits low.
// - Chop target select low chops the inhibits, high chops the phase lines.
// - Two active-low inhibits serve the AB pair and the CD pair alike.
// - The AB sense input regulates the AB pair, the CD sense input the CD pair, independently.
// - Step size high runs half-step; low runs full-step, wave or two-phase by state parity.
// - A low pulse on the translator reset returns it to state 1, phases 0101.
// - Each pair's drive flip-flop is set by each oscillator pulse and cleared by its comparator.
// - Chopping the phase lines turns on the idle line of a pair instead of cutting the active one.
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module spt_translator (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Step control pins from the host.
   input wire logic step_n,
   input wire logic rotation_dir,
   input wire logic step_size_sel,
   input wire logic translator_reset_n,
   input wire logic enable,
   input wire logic chop_target_sel,
   // Chopper pins.
   input wire logic sense_ab,
   input wire logic sense_cd,
   input wire logic chopper_osc,
   input wire logic chopper_sync_in,
   output logic chopper_sync_out,
   output logic chopper_sync_oe_n,
   // Power stage drive.
   output logic [3:0] phase,
   output logic inhibit_ab_n,
   output logic inhibit_cd_n,
   // Home indicator, open drain.
   output logic at_initial_state_out,
   output logic at_initial_state_oe_n
);
   import spt_pkg::*;

   typedef struct packed {
      logic [SPT_PIN_W-1:0] meta;
      logic [SPT_PIN_W-1:0] pin;
      logic step_d;
      logic [2:0] idx;
      logic [3:0] phase;
      logic inh_ab_n;
      logic inh_cd_n;
      logic home;
      logic [15:0] period;
      logic [31:0] prdata;
   } spt_main_type;

   spt_main_type r;
   spt_main_type next_r;
   spt_chop_if ch ();

   logic [SPT_PIN_W-1:0] pins_raw;
   logic [3:0] ph;
   logic inh_ab;
   logic inh_cd;
   logic setup;
   logic access;
   logic mapped;

   // Advance or retreat the translator by one or two states.
   function automatic logic [2:0] spt_advance(
      input logic [2:0] idx,
      input logic cw,
      input logic half
   );
      logic [2:0] inc;
      inc = half ? SPT_STEP_HALF : SPT_STEP_FULL;
      return cw ? 3'(idx + inc) : 3'(idx - inc);
   endfunction

   spt_chopper u_chop (
      .pclk(pclk),
      .presetn(presetn),
      .ch(ch)
   );

   always_comb begin
      pins_raw = '0;
      pins_raw[SPT_PIN_STEP] = step_n;
      pins_raw[SPT_PIN_DIR] = rotation_dir;
      pins_raw[SPT_PIN_HALF] = step_size_sel;
      pins_raw[SPT_PIN_TRST] = translator_reset_n;
      pins_raw[SPT_PIN_EN] = enable;
      pins_raw[SPT_PIN_CTRL] = chop_target_sel;
      pins_raw[SPT_PIN_SAB] = sense_ab;
      pins_raw[SPT_PIN_SCD] = sense_cd;
      pins_raw[SPT_PIN_OSC] = chopper_osc;
      pins_raw[SPT_PIN_SYNC] = chopper_sync_in;
   end

   // Synchronised levels and the period register handed to the chopper.
   assign ch.local_en = r.pin[SPT_PIN_OSC];
   assign ch.period = r.period;
   assign ch.sync_level = r.pin[SPT_PIN_SYNC];
   assign ch.sense_ab = r.pin[SPT_PIN_SAB];
   assign ch.sense_cd = r.pin[SPT_PIN_SCD];

   always_comb begin
      next_r = r;
      // Two-stage synchroniser for every pin.
      next_r.meta = pins_raw;
      next_r.pin = r.meta;
      next_r.step_d = r.pin[SPT_PIN_STEP];

      // Translator state.
      if (!r.pin[SPT_PIN_TRST]) begin
         next_r.idx = SPT_HOME_IDX;
      end else if (!r.step_d && r.pin[SPT_PIN_STEP]) begin
         // Step taken on the rising edge only, with current direction.
         next_r.idx = spt_advance(r.idx, r.pin[SPT_PIN_DIR],
                                  r.pin[SPT_PIN_HALF]);
      end

      // Base drive from the translator state.
      ph = spt_phase_of(r.idx);
      inh_ab = |ph[3:2];
      inh_cd = |ph[1:0];

      // Chopper gating, per pair from its own flip-flop.
      if (r.pin[SPT_PIN_CTRL]) begin
         if (!ch.ff_ab) begin
            ph[3:2] = spt_chop_pair(ph[3:2]);
         end
         if (!ch.ff_cd) begin
            ph[1:0] = spt_chop_pair(ph[1:0]);
         end
      end else begin
         inh_ab = inh_ab && ch.ff_ab;
         inh_cd = inh_cd && ch.ff_cd;
      end

      if (!r.pin[SPT_PIN_EN]) begin
         ph = 4'h0;
         inh_ab = 1'b0;
         inh_cd = 1'b0;
      end
      next_r.phase = ph;
      next_r.inh_ab_n = inh_ab;
      next_r.inh_cd_n = inh_cd;
      next_r.home = (r.idx == SPT_HOME_IDX);

      // APB slave: read data captured in setup, writes in access.
      setup = psel && !penable;
      access = psel && penable;
      mapped = (paddr == SPT_ADDR_CTRL) || (paddr == SPT_ADDR_STATUS);
      if (setup) begin
         next_r.prdata = 32'h0000_0000;
         if (paddr == SPT_ADDR_CTRL) begin
            next_r.prdata[SPT_CTRL_PERIOD_LSB +: SPT_CTRL_PERIOD_W] =
               r.period;
         end else if (paddr == SPT_ADDR_STATUS) begin
            next_r.prdata[SPT_ST_IDX_LSB +: 3] = r.idx;
            next_r.prdata[SPT_ST_HOME] = r.home;
            next_r.prdata[SPT_ST_FF_AB] = ch.ff_ab;
            next_r.prdata[SPT_ST_FF_CD] = ch.ff_cd;
            next_r.prdata[SPT_ST_HALF] = r.pin[SPT_PIN_HALF];
            next_r.prdata[SPT_ST_LOCAL] = r.pin[SPT_PIN_OSC];
            next_r.prdata[SPT_ST_PHASE_LSB +: 4] = r.phase;
         end
      end
      if (access && pwrite && paddr == SPT_ADDR_CTRL) begin
         next_r.period = pwdata[SPT_CTRL_PERIOD_LSB +: SPT_CTRL_PERIOD_W];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '{meta: SPT_PIN_RST, pin: SPT_PIN_RST, step_d: 1'b1,
                idx: SPT_HOME_IDX, phase: 4'h0, inh_ab_n: 1'b0,
                inh_cd_n: 1'b0, home: 1'b1, period: SPT_PERIOD_RST,
                prdata: 32'h0000_0000};
      end else begin
         r <= next_r;
      end
   end

   assign prdata = r.prdata;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   assign phase = r.phase;
   assign inhibit_ab_n = r.inh_ab_n;
   assign inhibit_cd_n = r.inh_cd_n;

   // Sync pin is driven only while the local oscillator runs.
   assign chopper_sync_out = ch.pulse;
   assign chopper_sync_oe_n = !r.pin[SPT_PIN_OSC];

   // Pull-down released while at home.
   assign at_initial_state_out = 1'b0;
   assign at_initial_state_oe_n = r.home;

endmodule

// file: bench/spt_monitor.sv
// Port checker of the stepper phase translator.
`timescale 1ns/1ns
module spt_monitor (
   // Watched inputs.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic step_n,
   input wire logic translator_reset_n,
   input wire logic enable,
   input wire logic chop_target_sel,
   input wire logic chopper_osc,
   // Watched outputs.
   input wire logic chopper_sync_out,
   input wire logic chopper_sync_oe_n,
   input wire logic [3:0] phase,
   input wire logic inhibit_ab_n,
   input wire logic inhibit_cd_n,
   input wire logic at_initial_state_out,
   input wire logic at_initial_state_oe_n
);
   import spt_pkg::*;
   logic step_q;
   logic [4:0] rise;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Step edges seen at the pin, aged by one bit per cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         step_q <= 1'b1;
         rise <= 5'h00;
      end else begin
         step_q <= step_n;
         rise <= {rise[3:0], step_n & ~step_q};
      end
   end
   sequence s_run;
      (enable && !chop_target_sel && translator_reset_n)[*8];
   endsequence
   sequence s_home;
      (enable && !chop_target_sel && !translator_reset_n)[*8];
   endsequence
   a_step_edge: assert property (s_run ##0 $changed(phase) |-> |rise[4:2])
      else $error("phase moved with no step edge");
   a_home_hold: assert property (s_home |-> phase == SPT_HOME_PHASE)
      else $error("translator reset left home");
   a_home_flag: assert property (phase == SPT_HOME_PHASE |->
      at_initial_state_oe_n && !at_initial_state_out)
      else $error("home pin not released");
   a_enable_off: assert property ((!enable)[*5] |->
      phase == 4'h0 && !inhibit_ab_n && !inhibit_cd_n)
      else $error("outputs live while disabled");
   a_ab_decay: assert property (phase[3:2] == 2'h0 |-> !inhibit_ab_n)
      else $error("idle pair ab not inhibited");
   a_cd_decay: assert property (phase[1:0] == 2'h0 |-> !inhibit_cd_n)
      else $error("idle pair cd not inhibited");
   a_sync_pulse: assert property (chopper_sync_out |=> !chopper_sync_out)
      else $error("sync pulse too long");
   a_sync_drive: assert property (chopper_osc[*4] |-> !chopper_sync_oe_n)
      else $error("sync pin not driven");
endmodule
bind spt_translator spt_monitor spt_monitor_inst (.pclk(pclk),
   .presetn(presetn), .step_n(step_n), .enable(enable),
   .translator_reset_n(translator_reset_n), .chopper_osc(chopper_osc),
   .chop_target_sel(chop_target_sel), .chopper_sync_out(chopper_sync_out),
   .chopper_sync_oe_n(chopper_sync_oe_n), .phase(phase),
   .inhibit_ab_n(inhibit_ab_n), .inhibit_cd_n(inhibit_cd_n),
   .at_initial_state_out(at_initial_state_out),
   .at_initial_state_oe_n(at_initial_state_oe_n));

// file: bench/spt_host_model.sv
// Host model that issues step pulses with direction and step size.
`timescale 1ns/1ns
module spt_host_model (
   // Clock and command.
   input wire logic pclk,
   input wire logic go,
   input wire logic cw,
   input wire logic half,
   // Step pins.
   output logic step_n,
   output logic rotation_dir,
   output logic step_size_sel,
   output logic busy
);
   logic [3:0] cnt = 4'h0;
   initial begin
      step_n = 1'b1;
      rotation_dir = 1'b1;
      step_size_sel = 1'b1;
   end
   assign busy = cnt != 4'h0;
   // Mode pins change on the same clock as the falling edge, three cycles before the rising edge.
   always @(posedge pclk) begin
      if (!busy && go) begin
         rotation_dir <= cw;
         step_size_sel <= half;
         step_n <= 1'b0;
         cnt <= 4'h1;
      end else if (busy) begin
         cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
         if (cnt == 4'h3) begin
            step_n <= 1'b1;
         end
      end
   end
endmodule

// file: bench/test_spt_translator.sv
// Self-checking bench of the stepper phase translator.
`timescale 1ns/1ns
module test_spt_translator;
   import spt_pkg::*;
   localparam logic [31:0] PTAB = 32'h5462_a891;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata;
   logic step_n, rot, size, trst_n, enable, ctl, s_ab, s_cd, osc, ext;
   logic sy_out, sy_oe_n, h_out, h_oe_n, inh_ab, inh_cd, go, cw, half, busy;
   logic [3:0] phase;
   logic [2:0] idx;
   int error_cnt, compares;
   wire sy_wire = sy_oe_n ? ext : sy_out;
   wire home = h_oe_n ? 1'b1 : h_out;
   spt_translator spt_translator_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .step_n(step_n), .rotation_dir(rot), .step_size_sel(size),
      .translator_reset_n(trst_n), .enable(enable), .chop_target_sel(ctl),
      .sense_ab(s_ab), .sense_cd(s_cd), .chopper_osc(osc),
      .chopper_sync_in(sy_wire), .chopper_sync_out(sy_out),
      .chopper_sync_oe_n(sy_oe_n), .phase(phase), .inhibit_ab_n(inh_ab),
      .inhibit_cd_n(inh_cd), .at_initial_state_out(h_out),
      .at_initial_state_oe_n(h_oe_n));
   spt_host_model spt_host_model_inst (.pclk(pclk), .go(go), .cw(cw),
      .half(half), .step_n(step_n), .rotation_dir(rot),
      .step_size_sel(size), .busy(busy));
   initial begin
      pclk = 0;
      forever #5 pclk = ~pclk;
   end
   task automatic summarize;
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge pclk);
   endtask
   task automatic chk(logic [31:0] g, logic [31:0] e);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic wait_for(ref logic s, input logic v);
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (s !== v && n < 99);
      if (s !== v) begin
         error_cnt++;
         summarize();
      end
   endtask
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d, x, logic e);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      wait_for(pready, 1'b1);
      if (!w) chk(prdata, x);
      chk(pslverr, e);
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task automatic step(logic d, logic h);
      cw <= d;
      half <= h;
      go <= 1;
      @(posedge pclk);
      go <= 0;
      wait_for(busy, 1'b0);
      if (trst_n) idx = idx + (d ? 3'h1 : 3'h7) * (h ? 3'h1 : 3'h2);
      tick(3);
   endtask
   task automatic look(logic [2:0] i);
      logic [3:0] p;
      p = PTAB[4 * (7 - i) +: 4];
      chk(phase, p);
      chk({inh_ab, inh_cd}, {|p[3:2], |p[1:0]});
      chk(home, i == 3'h0);
   endtask
   task automatic wpulse;
      wait_for(sy_out, 1'b1);
      tick(4);
   endtask
   initial begin
      {presetn, psel, penable, pwrite, go, cw, half, s_ab, s_cd, ctl} = '0;
      {trst_n, enable, osc, ext} = 4'he;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      error_cnt = 0;
      compares = 0;
      idx = 3'h0;
      void'($urandom(95));
      tick(12);
      presetn <= 1;
      tick(6);
      look(idx);
      apb(0, SPT_ADDR_CTRL, 0, 32'h0000_00c8, 0);
      apb(1, SPT_ADDR_CTRL, 32'h0000_0010, 0, 0);
      apb(0, SPT_ADDR_CTRL, 0, 32'h0000_0010, 0);
      apb(1, SPT_ADDR_STATUS, 32'hffff_ffff, 0, 0);
      apb(0, SPT_ADDR_STATUS, 0, 32'h0000_05f8, 0);
      apb(0, 12'h008, 0, 0, 1);
      repeat (40) begin
         step(1'($urandom_range(1)), 1'($urandom_range(1)));
         look(idx);
      end
      trst_n <= 0;
      tick(8);
      step(1, 0);
      idx = 3'h0;
      look(idx);
      trst_n <= 1;
      enable <= 0;
      tick(6);
      chk({phase, inh_ab, inh_cd}, 0);
      enable <= 1;
      s_ab <= 1;
      wpulse();
      chk({inh_ab, inh_cd, phase}, 6'h15);
      s_ab <= 0;
      wpulse();
      chk(inh_ab, 1);
      ctl <= 1;
      s_cd <= 1;
      wpulse();
      chk({inh_ab, inh_cd, phase}, 6'h37);
      s_cd <= 0;
      ctl <= 0;
      osc <= 0;
      s_ab <= 1;
      tick(8);
      chk({sy_oe_n, inh_ab}, 2'h2);
      s_ab <= 0;
      tick(40);
      chk(inh_ab, 0);
      ext <= 1;
      tick(6);
      chk(inh_ab, 1);
      summarize();
   end
endmodule
